// ===== rtl/nic_misc_csr_bank.sv
// misc control/status registers: transmit irq enables, drop counter,
// bit-banged eeprom port, count-down timer and wake-up control
// assumes event inputs are single-cycle pulses on clk_sys; link_up and
// rom_dout come from pins and are synchronised here
//
// Functional notes
// R1: tx descriptor unavailable irq needs its enable and normal summary enable.
// R2: tx stopped irq needs its enable and abnormal summary enable.
// R3: tx done irq needs its enable and normal summary; enable resets 0.
// R4: drop count increments on each packet dropped for lack of descriptor.
// R5: reading the drop register clears the drop count.
// R6: count overflow sets bit 16 flag; read clears it.
// R7: eeprom read only while read control and select are set.
// R8: eeprom write only while write control and select are set.
// R9: returned eeprom data shows at read-only bit 3; resets to 1.
// R10: bit 2 drives the data line toward the eeprom; resets to 1.
// R11: software toggles bit 1 to make the eeprom clock; resets to 1.
// R12: chip select asserted while bit 0 is 1; resets to 1.
// R13: timer bit 16 selects repeating mode, else single shot.
// R14: timer loads written 16-bit value, counts down every 204 us.
// R15: crc-16 seed is zeros when bit 30 clear, ones when set.
// R16: pattern matches one to five count only when bits 29..25 enabled.
// R17: link-down enable sets link change flag on up-to-down.
// R18: link-up enable sets link change flag on down-to-up.
// R19: wake frame enable turns matched wake frame into power event.
// R20: link change flag cleared only by write-one or power-up reset.
// R21: normal summary enable gates every enabled normal source.
// R22: abnormal summary enable gates every enabled abnormal source.
// R23: timer flags expiry at zero; reloads in repeat mode, else stops.
// R24: with select clear the eeprom pins stay inactive.
`timescale 1ns/100ps

module nic_misc_csr_bank
  import nic_misc_csr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic por_n,
  input wire axil_req_t axil_req,
  output axil_rsp_t axil_rsp,
  input wire logic tx_desc_unavail_evt,
  input wire logic tx_stopped_evt,
  input wire logic tx_done_evt,
  output logic tx_desc_unavail_irq,
  output logic tx_stopped_irq,
  output logic tx_done_irq,
  input wire logic rx_drop_evt,
  output logic eeprom_chip_sel,
  output logic eeprom_clk,
  output logic eeprom_serial_to_rom,
  input wire logic eeprom_serial_from_rom,
  output logic timer_expired,
  output logic [15:0] crc16_seed,
  output logic [4:0] pattern_match_en,
  input wire logic [4:0] pattern_match,
  input wire logic link_up,
  output logic pm_event_status,
  input wire logic pm_event_clear
);

  typedef struct packed {
    logic normal_summary_irq_en;
    logic abnormal_summary_irq_en;
    logic tx_desc_unavail_irq_en;
    logic tx_stopped_irq_en;
    logic tx_done_irq_en;
    logic [15:0] drop_count;
    logic drop_count_overflow;
    logic eeprom_read_allow;
    logic eeprom_write_allow;
    logic eeprom_port_select;
    logic from_rom;
    logic to_rom;
    logic clk_bit;
    logic chip_sel_bit;
    logic rom_s1;
    logic rom_s2;
    logic timer_repeat_mode;
    logic [15:0] timer_load_value;
    logic [15:0] timer_count;
    logic timer_run;
    logic [11:0] prescale;
    logic timer_exp;
    logic crc16_seed_type;
    logic [4:0] pattern_en;
    logic link_down_detect_en;
    logic link_up_detect_en;
    logic wake_frame_event_en;
    logic pm_evt;
    logic link_s1;
    logic link_s2;
    logic link_s3;
    logic aw_got;
    logic w_got;
    logic [AXIL_AW-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  // flags that survive the ordinary reset, cleared only by a write-one or at power-up
  logic link_change_flag_r;
  logic link_change_flag_nxt;
  logic wake_frame_rx_r;
  logic wake_frame_rx_nxt;

  function automatic reg_id_t reg_decode(input logic [AXIL_AW-1:0] addr);
    case (addr)
      OFS_IRQ_EN: reg_decode = REG_IRQ_EN;
      OFS_DROP: reg_decode = REG_DROP;
      OFS_PORT: reg_decode = REG_PORT;
      OFS_TIMER: reg_decode = REG_TIMER;
      OFS_WAKE: reg_decode = REG_WAKE;
      default: reg_decode = REG_NONE;
    endcase
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  reg_id_t wr_id;
  reg_id_t rd_id;
  logic drop_read;
  logic link_rise;
  logic link_fall;
  logic wake_hit;
  logic tick;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic rom_read_ok;
  logic rom_write_ok;

  assign aw_hs = axil_req.awvalid && axil_rsp.awready;
  assign w_hs = axil_req.wvalid && axil_rsp.wready;
  assign ar_hs = axil_req.arvalid && axil_rsp.arready;
  assign do_write = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign wr_id = reg_decode(st_r.waddr);
  assign rd_id = reg_decode(axil_req.araddr);
  assign drop_read = ar_hs && (rd_id == REG_DROP);
  // only the second and third sync stages feed the edge detector
  assign link_rise = st_r.link_s2 && !st_r.link_s3;
  assign link_fall = !st_r.link_s2 && st_r.link_s3;
  assign wake_hit = |(pattern_match & st_r.pattern_en); // R16
  assign tick = st_r.timer_run && (st_r.prescale == TICK_LAST);
  assign rom_read_ok = st_r.eeprom_read_allow && st_r.eeprom_port_select; // R7
  assign rom_write_ok = st_r.eeprom_write_allow && st_r.eeprom_port_select; // R8

  // one register view serves the read path and the byte-lane merge of a write,
  // so a partial write keeps the lanes of the register actually addressed
  function automatic logic [31:0] reg_view(input reg_id_t id);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (id)
      REG_IRQ_EN:
      begin
        w[BIT_NORMAL_SUM] = st_r.normal_summary_irq_en;
        w[BIT_ABNORMAL_SUM] = st_r.abnormal_summary_irq_en;
        w[BIT_TX_DESC_UNAVAIL] = st_r.tx_desc_unavail_irq_en;
        w[BIT_TX_STOPPED] = st_r.tx_stopped_irq_en;
        w[BIT_TX_DONE] = st_r.tx_done_irq_en;
      end
      REG_DROP:
      begin
        w[BIT_DROP_OVF] = st_r.drop_count_overflow;
        w[15:0] = st_r.drop_count;
      end
      REG_PORT:
      begin
        w[BIT_ROM_RD] = st_r.eeprom_read_allow;
        w[BIT_ROM_WR] = st_r.eeprom_write_allow;
        w[BIT_ROM_SEL] = st_r.eeprom_port_select;
        w[BIT_ROM_DOUT] = st_r.from_rom; // R9
        w[BIT_ROM_DIN] = st_r.to_rom;
        w[BIT_ROM_CLK] = st_r.clk_bit;
        w[BIT_ROM_CS] = st_r.chip_sel_bit;
      end
      REG_TIMER:
      begin
        w[BIT_TIMER_REPEAT] = st_r.timer_repeat_mode;
        w[15:0] = st_r.timer_count;
      end
      REG_WAKE:
      begin
        w[BIT_CRC_SEED] = st_r.crc16_seed_type;
        w[BIT_PAT_EN_LO +: 5] = st_r.pattern_en;
        w[BIT_LINK_DOWN_EN] = st_r.link_down_detect_en;
        w[BIT_LINK_UP_EN] = st_r.link_up_detect_en;
        w[BIT_WAKE_FRAME_EN] = st_r.wake_frame_event_en;
        w[BIT_WAKE_FRAME_RX] = wake_frame_rx_r;
        w[BIT_LINK_CHANGE] = link_change_flag_r;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  always_comb
  begin
    rd_word = reg_view(rd_id);
  end

  always_comb
  begin
    st_nxt = st_r;
    wr_word = strb_merge(reg_view(wr_id), st_r.wdata, st_r.wstrb);
    link_change_flag_nxt = link_change_flag_r;
    wake_frame_rx_nxt = wake_frame_rx_r;

    st_nxt.link_s1 = link_up;
    st_nxt.link_s2 = st_r.link_s1;
    st_nxt.link_s3 = st_r.link_s2;
    st_nxt.rom_s1 = eeprom_serial_from_rom;
    st_nxt.rom_s2 = st_r.rom_s1;
    if (rom_read_ok)
    begin
      st_nxt.from_rom = st_r.rom_s2; // R9
    end

    // bus write channel: address and data may arrive in either order
    if (aw_hs)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.waddr = axil_req.awaddr;
    end
    if (w_hs)
    begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = axil_req.wdata;
      st_nxt.wstrb = axil_req.wstrb;
    end
    if (st_r.bvalid && axil_req.bready)
    begin
      st_nxt.bvalid = 1'b0;
    end

    // timer count-down, a write below takes priority
    st_nxt.timer_exp = 1'b0;
    if (st_r.timer_run)
    begin
      st_nxt.prescale = tick ? 12'h000 : 12'(st_r.prescale + 12'h001);
      if (tick)
      begin
        st_nxt.timer_count = 16'(st_r.timer_count - 16'h0001); // R14
        if (st_r.timer_count == 16'h0001)
        begin
          st_nxt.timer_exp = 1'b1; // R23
          st_nxt.timer_run = st_r.timer_repeat_mode; // R13
          st_nxt.timer_count = st_r.timer_repeat_mode ? st_r.timer_load_value : 16'h0000;
        end
      end
    end

    // drop counter: clear on read, a drop in the read cycle still counts
    if (drop_read)
    begin
      st_nxt.drop_count = 16'h0000; // R5
      st_nxt.drop_count_overflow = 1'b0; // R6
    end
    if (rx_drop_evt)
    begin
      st_nxt.drop_count = drop_read ? 16'h0001 : 16'(st_r.drop_count + 16'h0001); // R4
      if (!drop_read && st_r.drop_count == 16'hFFFF)
      begin
        st_nxt.drop_count_overflow = 1'b1; // R6
      end
    end

    if (do_write)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = (wr_id == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (wr_id)
        REG_IRQ_EN:
        begin
          st_nxt.normal_summary_irq_en = wr_word[BIT_NORMAL_SUM];
          st_nxt.abnormal_summary_irq_en = wr_word[BIT_ABNORMAL_SUM];
          st_nxt.tx_desc_unavail_irq_en = wr_word[BIT_TX_DESC_UNAVAIL];
          st_nxt.tx_stopped_irq_en = wr_word[BIT_TX_STOPPED];
          st_nxt.tx_done_irq_en = wr_word[BIT_TX_DONE];
        end
        REG_PORT:
        begin
          st_nxt.eeprom_read_allow = wr_word[BIT_ROM_RD];
          st_nxt.eeprom_write_allow = wr_word[BIT_ROM_WR];
          st_nxt.eeprom_port_select = wr_word[BIT_ROM_SEL];
          st_nxt.to_rom = wr_word[BIT_ROM_DIN]; // R10
          st_nxt.clk_bit = wr_word[BIT_ROM_CLK]; // R11
          st_nxt.chip_sel_bit = wr_word[BIT_ROM_CS];
        end
        REG_TIMER:
        begin
          st_nxt.timer_repeat_mode = wr_word[BIT_TIMER_REPEAT]; // R13
          st_nxt.timer_load_value = wr_word[15:0]; // R14
          st_nxt.timer_count = wr_word[15:0];
          st_nxt.timer_run = (wr_word[15:0] != 16'h0000);
          st_nxt.prescale = 12'h000;
        end
        REG_WAKE:
        begin
          st_nxt.crc16_seed_type = wr_word[BIT_CRC_SEED];
          st_nxt.pattern_en = wr_word[BIT_PAT_EN_LO +: 5];
          st_nxt.link_down_detect_en = wr_word[BIT_LINK_DOWN_EN];
          st_nxt.link_up_detect_en = wr_word[BIT_LINK_UP_EN];
          st_nxt.wake_frame_event_en = wr_word[BIT_WAKE_FRAME_EN];
          if (st_r.wdata[BIT_LINK_CHANGE] && st_r.wstrb[0])
          begin
            link_change_flag_nxt = 1'b0; // R20
          end
          if (st_r.wdata[BIT_WAKE_FRAME_RX] && st_r.wstrb[0])
          begin
            wake_frame_rx_nxt = 1'b0;
          end
        end
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
    end

    // hardware sets win over a write-one clear in the same cycle
    if ((st_r.link_down_detect_en && link_fall) || (st_r.link_up_detect_en && link_rise))
    begin
      link_change_flag_nxt = 1'b1; // R17 R18
    end
    if (wake_hit)
    begin
      wake_frame_rx_nxt = 1'b1;
    end
    if (pm_event_clear)
    begin
      st_nxt.pm_evt = 1'b0;
    end
    if (wake_hit && st_r.wake_frame_event_en)
    begin
      st_nxt.pm_evt = 1'b1; // R19
    end

    // read channel: one outstanding read, data registered
    if (st_r.rvalid && axil_req.rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    if (ar_hs)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_word;
      st_nxt.rresp = (rd_id == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.from_rom <= PORT_PIN_RESET; // R9
      st_r.to_rom <= PORT_PIN_RESET; // R10
      st_r.clk_bit <= PORT_PIN_RESET; // R11
      st_r.chip_sel_bit <= PORT_PIN_RESET; // R12
      st_r.rom_s1 <= PORT_PIN_RESET;
      st_r.rom_s2 <= PORT_PIN_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // these status flags ignore the ordinary reset by design
  always_ff @(posedge clk_sys or negedge por_n)
  begin
    if (!por_n)
    begin
      link_change_flag_r <= 1'b0; // R20
      wake_frame_rx_r <= 1'b0;
    end
    else
    begin
      link_change_flag_r <= link_change_flag_nxt;
      wake_frame_rx_r <= wake_frame_rx_nxt;
    end
  end

  assign axil_rsp.awready = !st_r.aw_got && !st_r.bvalid;
  assign axil_rsp.wready = !st_r.w_got && !st_r.bvalid;
  assign axil_rsp.bvalid = st_r.bvalid;
  assign axil_rsp.bresp = st_r.bresp;
  assign axil_rsp.arready = !st_r.rvalid;
  assign axil_rsp.rvalid = st_r.rvalid;
  assign axil_rsp.rdata = st_r.rdata;
  assign axil_rsp.rresp = st_r.rresp;

  assign tx_desc_unavail_irq = tx_desc_unavail_evt && st_r.tx_desc_unavail_irq_en
    && st_r.normal_summary_irq_en; // R1 R21
  assign tx_stopped_irq = tx_stopped_evt && st_r.tx_stopped_irq_en
    && st_r.abnormal_summary_irq_en; // R2 R22
  assign tx_done_irq = tx_done_evt && st_r.tx_done_irq_en && st_r.normal_summary_irq_en; // R3

  // pins idle low whenever the port is not selected and enabled
  assign eeprom_chip_sel = (rom_read_ok || rom_write_ok) && st_r.chip_sel_bit; // R12 R24
  assign eeprom_clk = (rom_read_ok || rom_write_ok) && st_r.clk_bit; // R11 R24
  assign eeprom_serial_to_rom = rom_write_ok && st_r.to_rom; // R10 R8
  assign timer_expired = st_r.timer_exp;
  assign crc16_seed = st_r.crc16_seed_type ? CRC_SEED_ONES : CRC_SEED_ZERO; // R15
  assign pattern_match_en = st_r.pattern_en;
  assign pm_event_status = st_r.pm_evt;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_irq_normal_gate: assert property ( // R1 R3
    (tx_desc_unavail_irq || tx_done_irq) |-> st_r.normal_summary_irq_en)
    else $error("normal irq without summary enable");
  a_irq_abnormal_gate: assert property ( // R2
    tx_stopped_irq |-> (st_r.abnormal_summary_irq_en && tx_stopped_evt))
    else $error("abnormal irq ungated");
  a_drop_count_up: assert property ( // R4
    (rx_drop_evt && !drop_read && st_r.drop_count != 16'hFFFF)
    |=> st_r.drop_count == 16'($past(st_r.drop_count) + 16'h0001))
    else $error("drop count did not advance");
  a_drop_read_clear: assert property ( // R5
    drop_read
    |=> (st_r.drop_count == {15'h0000, $past(rx_drop_evt)}) && !st_r.drop_count_overflow)
    else $error("drop register not cleared by read");
  a_drop_ovf_set: assert property ( // R6
    (rx_drop_evt && !drop_read && st_r.drop_count == 16'hFFFF)
    |=> st_r.drop_count_overflow && st_r.drop_count == 16'h0000)
    else $error("overflow flag not set");
  a_rom_sample_hold: assert property ( // R7
    !rom_read_ok |=> $stable(st_r.from_rom))
    else $error("eeprom data sampled while read not allowed");
  a_rom_pins_idle: assert property ( // R24
    !st_r.eeprom_port_select |-> !eeprom_chip_sel && !eeprom_clk && !eeprom_serial_to_rom)
    else $error("eeprom pins active without select");
  a_timer_step: assert property ( // R14
    (tick && !do_write && st_r.timer_count > 16'h0001)
    |=> st_r.timer_count == 16'($past(st_r.timer_count) - 16'h0001) && !timer_expired)
    else $error("timer did not count down");
  a_timer_expire: assert property ( // R23
    (tick && !do_write && st_r.timer_count == 16'h0001)
    |=> timer_expired && (st_r.timer_run == st_r.timer_repeat_mode) ##1 !timer_expired)
    else $error("timer expiry wrong");
  a_link_change_set: assert property ( // R17 R18
    ((st_r.link_up_detect_en && link_rise) || (st_r.link_down_detect_en && link_fall))
    |=> link_change_flag_r)
    else $error("link change flag not set");
  a_pm_event_set: assert property ( // R19
    (wake_hit && st_r.wake_frame_event_en) |=> pm_event_status)
    else $error("wake frame did not raise power event");

endmodule // nic_misc_csr_bank

// ===== rtl/nic_misc_csr_pkg.sv
// package for the misc control/status register bank of the network controller
// assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus
package nic_misc_csr_pkg;

  localparam int AXIL_AW = 8;

  // byte offsets of the registers
  localparam logic [7:0] OFS_IRQ_EN = 8'h38;
  localparam logic [7:0] OFS_DROP = 8'h40;
  localparam logic [7:0] OFS_PORT = 8'h48;
  localparam logic [7:0] OFS_TIMER = 8'h58;
  localparam logic [7:0] OFS_WAKE = 8'h68;

  // interrupt enable fields
  localparam int BIT_NORMAL_SUM = 16;
  localparam int BIT_ABNORMAL_SUM = 15;
  localparam int BIT_TX_DESC_UNAVAIL = 2;
  localparam int BIT_TX_STOPPED = 1;
  localparam int BIT_TX_DONE = 0;

  // drop counter fields
  localparam int BIT_DROP_OVF = 16;

  // eeprom port fields
  localparam int BIT_ROM_RD = 14;
  localparam int BIT_ROM_WR = 13;
  localparam int BIT_ROM_SEL = 11;
  localparam int BIT_ROM_DOUT = 3;
  localparam int BIT_ROM_DIN = 2;
  localparam int BIT_ROM_CLK = 1;
  localparam int BIT_ROM_CS = 0;
  localparam logic PORT_PIN_RESET = 1'b1;

  // timer fields and tick period
  localparam int BIT_TIMER_REPEAT = 16;
  localparam int TIMER_TICK_NS = 204000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_CYCLES = TIMER_TICK_NS / CLK_PERIOD_NS;
  localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);

  // wake-up control/status fields
  localparam int BIT_CRC_SEED = 30;
  localparam int BIT_PAT_EN_LO = 25;
  localparam int BIT_LINK_DOWN_EN = 17;
  localparam int BIT_LINK_UP_EN = 16;
  localparam int BIT_WAKE_FRAME_EN = 10;
  localparam int BIT_WAKE_FRAME_RX = 2;
  localparam int BIT_LINK_CHANGE = 0;
  localparam logic [15:0] CRC_SEED_ZERO = 16'h0000;
  localparam logic [15:0] CRC_SEED_ONES = 16'hFFFF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {REG_NONE, REG_IRQ_EN, REG_DROP, REG_PORT, REG_TIMER, REG_WAKE} reg_id_t;

  typedef struct packed {
    logic awvalid;
    logic [AXIL_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXIL_AW-1:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

endpackage

// ===== tb/eeprom_model.sv
// behavioural serial eeprom on the bit-banged port
// assumes software makes every clock edge; the model never runs on its own
`timescale 1ns/100ps

module eeprom_model (
  input wire logic rom_clk,
  input wire logic rom_cs,
  input wire logic rom_din,
  output logic rom_dout
);
  logic [3:0] edges_r = 4'h0;

  // incoming data is not stored; each selected rising clock edge turns the answer bit over
  always @(posedge rom_clk)
    if (rom_cs)
      edges_r <= edges_r + 4'h1;

  // a deselected part releases the line, which its pull-up takes high
  assign rom_dout = rom_cs ? ~edges_r[0] : 1'b1;
endmodule // eeprom_model

// ===== tb/nic_misc_csr_bank_tb_top.sv
// self-checking bench for the misc control/status register bank
// assumes the eeprom model beside it and a 20 MHz clock
`timescale 1ns/100ps

`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

module nic_misc_csr_bank_tb_top;
  import nic_misc_csr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b0;
  axil_req_t req = '0;
  axil_rsp_t rsp;
  logic [2:0] evt = 3'h0;
  logic [2:0] irq;
  logic rx_drop = 1'b0;
  logic rom_cs, rom_clk, rom_di, rom_do, tmr_exp, pm;
  logic pm_clr = 1'b0;
  logic link = 1'b0;
  logic [15:0] seed;
  logic [4:0] pat_en;
  logic [4:0] pat = 5'h00;
  int n_mismatch = 0;
  int checks_done = 0;
  int n;
  logic [31:0] ie_tab [4] = '{32'h00000007, 32'h00010007, 32'h00008007, 32'h00018003};
  logic [2:0] irq_exp [4] = '{3'b000, 3'b101, 3'b010, 3'b011};

  always #25 clk_sys = ~clk_sys;

  nic_misc_csr_bank dut_u (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .por_n(por_n),
    .axil_req(req),
    .axil_rsp(rsp),
    .tx_desc_unavail_evt(evt[2]),
    .tx_stopped_evt(evt[1]),
    .tx_done_evt(evt[0]),
    .tx_desc_unavail_irq(irq[2]),
    .tx_stopped_irq(irq[1]),
    .tx_done_irq(irq[0]),
    .rx_drop_evt(rx_drop),
    .eeprom_chip_sel(rom_cs),
    .eeprom_clk(rom_clk),
    .eeprom_serial_to_rom(rom_di),
    .eeprom_serial_from_rom(rom_do),
    .timer_expired(tmr_exp),
    .crc16_seed(seed),
    .pattern_match_en(pat_en),
    .pattern_match(pat),
    .link_up(link),
    .pm_event_status(pm),
    .pm_event_clear(pm_clr)
  );

  eeprom_model rom_u (
    .rom_clk(rom_clk),
    .rom_cs(rom_cs),
    .rom_din(rom_di),
    .rom_dout(rom_do)
  );

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY, input logic [3:0] s = 4'hF);
    bit done;
    done = 0;
    @(posedge clk_sys);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= s;
    req.bready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++)
    begin
      @(posedge clk_sys);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.bvalid)
      begin
        `CHK(rsp.bresp, r)
        req.bready <= 1'b0;
        done = 1;
      end
    end
    if (!done)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
    bit done;
    done = 0;
    @(posedge clk_sys);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++)
    begin
      @(posedge clk_sys);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (rsp.rvalid)
      begin
        `CHK(rsp.rdata, e)
        `CHK(rsp.rresp, r)
        req.rready <= 1'b0;
        done = 1;
      end
    end
    if (!done)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  // measures edges up to the next expiry pulse; the bound covers two ticks
  task automatic wait_exp(output int c);
    c = 0;
    do
    begin
      @(posedge clk_sys);
      c++;
    end while (tmr_exp !== 1'b1 && c < 9000);
    if (c >= 9000)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  task automatic pulse(input logic [4:0] v);
    pat <= v;
    @(posedge clk_sys);
    pat <= 5'h00;
    repeat (3) @(posedge clk_sys);
  endtask

  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    `CHK({rom_cs, rom_clk, rom_di}, 3'b000)
    rd(OFS_IRQ_EN, 32'h0);
    rd(OFS_PORT, 32'h0000000F);
    rd(OFS_TIMER, 32'h0);
    rd(OFS_WAKE, 32'h0);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'hFFFFFFFF, RESP_SLVERR);
    $display("test reset done");
    evt <= 3'h7;
    for (int k = 0; k < 4; k++)
    begin
      wr(OFS_IRQ_EN, ie_tab[k]);
      `CHK(irq, irq_exp[k])
    end
    wr(OFS_IRQ_EN, 32'h0, RESP_OKAY, 4'h2);
    rd(OFS_IRQ_EN, 32'h00010003);
    `CHK(irq, 3'b001)
    evt <= 3'h0;
    $display("test irq done");
    // chip select rises with the clock low, so the part sees a clean first edge
    wr(OFS_PORT, 32'h00006805);
    `CHK({rom_cs, rom_clk, rom_di}, 3'b101)
    wr(OFS_PORT, 32'h00006807);
    `CHK({rom_cs, rom_clk, rom_di}, 3'b111)
    // returned data needs its sync stages before it reads back
    repeat (2) @(posedge clk_sys);
    rd(OFS_PORT, 32'h00006807);
    wr(OFS_PORT, 32'h00002805);
    wr(OFS_PORT, 32'h00002807);
    repeat (2) @(posedge clk_sys);
    rd(OFS_PORT, 32'h00002807);
    wr(OFS_PORT, 32'h00004807);
    `CHK({rom_cs, rom_di}, 2'b10)
    repeat (2) @(posedge clk_sys);
    rd(OFS_PORT, 32'h0000480F);
    wr(OFS_PORT, 32'h00006007);
    `CHK({rom_cs, rom_clk, rom_di}, 3'b000)
    $display("test eeprom done");
    rx_drop <= 1'b1;
    repeat (65537) @(posedge clk_sys);
    rx_drop <= 1'b0;
    rd(OFS_DROP, 32'h00010001);
    rd(OFS_DROP, 32'h0);
    $display("test drop done");
    wr(OFS_TIMER, 32'h00000002);
    wait_exp(n);
    `CHK(n inside {[8150:8170]}, 1'b1)
    rd(OFS_TIMER, 32'h0);
    wr(OFS_TIMER, 32'h00010001);
    wait_exp(n);
    wait_exp(n);
    `CHK(n inside {[4075:4085]}, 1'b1)
    rd(OFS_TIMER, 32'h00010001);
    wr(OFS_TIMER, 32'h0);
    $display("test timer done");
    wr(OFS_WAKE, 32'h7E030400);
    `CHK({seed, pat_en}, {16'hFFFF, 5'h1F})
    link <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rd(OFS_WAKE, 32'h7E030401);
    pulse(5'h10);
    `CHK(pm, 1'b1)
    rd(OFS_WAKE, 32'h7E030405);
    wr(OFS_WAKE, 32'h7E030401);
    rd(OFS_WAKE, 32'h7E030404);
    link <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rd(OFS_WAKE, 32'h7E030405);
    pm_clr <= 1'b1;
    @(posedge clk_sys);
    pm_clr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK(pm, 1'b0)
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(OFS_WAKE, 32'h00000005);
    `CHK({seed, pat_en}, 21'h0)
    wr(OFS_WAKE, 32'h00000400);
    pulse(5'h1F);
    `CHK(pm, 1'b0)
    $display("test wake done");
    wrap_up();
  end
endmodule // nic_misc_csr_bank_tb_top
